// file: perf_cfg.svh
`ifndef PERF_CFG_SVH
`define PERF_CFG_SVH

// ----------------------------------------------------------------------
// clocking
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define IO_PERIOD_NS     30
`define IO_DIV_CYC       ((`IO_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CTRL        8'h00
`define ADDR_EVSEL       8'h04
`define ADDR_CNT0        8'h08
`define ADDR_CNT1        8'h0c
`define ADDR_SAVE        8'h10
`define ADDR_STATUS      8'h14

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define CR_PCE_BIT       0
`define CR_VAR_BIT       1
`define CR_DEF_MASK      32'h0000_0003
`define CR_RST           32'h0000_0000
`define SEL0_LSB         0
`define SEL1_LSB         16
`define STAT_MGMT_BIT    0
`define STAT_HALT_BIT    1
`define MISALIGN_STALL   2'h3
`define PEND_W           16

`endif

// file: perf_event_counter_unit.sv
// Behaviour
// RL1 - two monitor pins, one per event counter, show each counter's activity.
// RL2 - pins move only on the slower io tick yet their toggles equal the increments; the code saturates the pending count at 16 bits.
// RL3 - with counter_read_enable set the counter read works at any level, else only level 0.
// RL4 - entering system management mode saves the control register; resume restores it.
// RL5 - resume checks only truly reserved bits, so a set read enable does not shut down.
// RL6 - code 101110 counts every non-cacheable write, SIMD ones included.
// RL7 - code 111011 counts SIMD write-hit stall clocks while buffers busy or write-empty off.
// RL8 - codes 110001 and 110100 count once per access, misaligned ones too.
// RL9 - code 110110 charges a misaligned read three clocks unless it missed the TLB.
// RL10 - multiply interlock clocks count only when no intervening branch was taken.
// RL11 - each increment crosses to the io rate without loss or duplication; the code drops increments once the 16-bit pending count saturates.
`timescale 1ns/1ns
`default_nettype none
`include "perf_cfg.svh"

module perf_event_counter_unit (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output var  logic [31:0] rdata_out,
  input  wire logic        nc_write_in,
  input  wire logic        simd_nc_write_in,
  input  wire logic        simd_wr_stall_in,
  input  wire logic        wb_nonempty_in,
  input  wire logic        ext_write_buffer_empty_n_in,
  input  wire logic        simd_rd_miss_in,
  input  wire logic        simd_wr_miss_in,
  input  wire logic        rd_stall_clk_in,
  input  wire logic        rd_misalign_done_in,
  input  wire logic        tlb_miss_in,
  input  wire logic        mul_interlock_in,
  input  wire logic        branch_taken_in,
  input  wire logic        counter_read_instr_in,
  input  wire logic [1:0]  cpl_in,
  input  wire logic        counter_sel_in,
  output var  logic        read_valid_out,
  output var  logic        read_fault_out,
  output var  logic [31:0] read_data_out,
  input  wire logic        sysmgmt_enter_in,
  input  wire logic        resume_from_sysmgmt_in,
  output var  logic        system_management_mode_out,
  output var  logic        shutdown_out,
  output var  logic [1:0]  monitor_status_pins_out
);

  localparam perf_pkg::main_state_t MAIN_RST = '{
    st:      perf_pkg::ST_RUN,
    cr:      `CR_RST,
    default: '0
  };

  perf_pkg::main_state_t s_q;
  perf_pkg::main_state_t s_d;
  logic [1:0]            inc0;
  logic [1:0]            inc1;
  logic [1:0]            nc_cnt;
  logic                  wr_stall;
  logic                  mul_stall;
  logic [1:0]            rd_stall;
  logic                  cnt0_wr;
  logic                  cnt1_wr;

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  function automatic logic [1:0] event_incr(
    input logic [5:0] sel,
    input logic       variant,
    input logic [1:0] nc,
    input logic       wst,
    input logic       mul,
    input logic       rdm,
    input logic       wrm,
    input logic [1:0] rst
  );
    logic [1:0] r;
    r = 2'h0;
    unique case (sel)
      perf_pkg::EV_NC_WRITE: r = nc; // [RL6]
      perf_pkg::EV_RD_MISS:  r = {1'b0, rdm}; // [RL8]
      perf_pkg::EV_WR_MISS:  r = {1'b0, wrm}; // [RL8]
      perf_pkg::EV_RD_STALL: r = rst; // [RL9]
      perf_pkg::EV_WR_STALL: r = {1'b0, variant ? mul : wst}; // [RL7] [RL10]
      default:               r = 2'h0;
    endcase
    return r;
  endfunction : event_incr

  always_comb begin
    nc_cnt    = {1'b0, nc_write_in} + {1'b0, simd_nc_write_in}; // [RL6]
    wr_stall  = simd_wr_stall_in && (wb_nonempty_in || s_q.wbuf_n[1]); // [RL7]
    mul_stall = mul_interlock_in && !branch_taken_in; // [RL10]
    if (rd_misalign_done_in && !tlb_miss_in) begin
      rd_stall = `MISALIGN_STALL; // [RL9]
    end else begin
      rd_stall = {1'b0, rd_stall_clk_in};
    end
    inc0 = event_incr(s_q.sel0, s_q.cr[`CR_VAR_BIT], nc_cnt, wr_stall, mul_stall,
                      simd_rd_miss_in, simd_wr_miss_in, rd_stall);
    inc1 = event_incr(s_q.sel1, s_q.cr[`CR_VAR_BIT], nc_cnt, wr_stall, mul_stall,
                      simd_rd_miss_in, simd_wr_miss_in, rd_stall);
    cnt0_wr = wr_in && (addr_in == `ADDR_CNT0);
    cnt1_wr = wr_in && (addr_in == `ADDR_CNT1);
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.wbuf_n = {s_q.wbuf_n[0], ext_write_buffer_empty_n_in};
    s_d.tick   = (s_q.div == 4'(`IO_DIV_CYC - 1));
    s_d.div    = s_d.tick ? 4'h0 : s_q.div + 4'h1;
    s_d.cnt0   = s_q.cnt0 + {30'h0, inc0};
    s_d.cnt1   = s_q.cnt1 + {30'h0, inc1};
    s_d.rdata  = 32'h0000_0000;
    s_d.rvalid = 1'b0;
    s_d.rfault = 1'b0;
    s_d.rddata = 32'h0000_0000;

    if (wr_in) begin
      unique case (addr_in)
        `ADDR_CTRL:  s_d.cr = wdata_in & `CR_DEF_MASK;
        `ADDR_EVSEL: begin
          s_d.sel0 = wdata_in[`SEL0_LSB +: 6];
          s_d.sel1 = wdata_in[`SEL1_LSB +: 6];
        end
        `ADDR_CNT0:  s_d.cnt0 = wdata_in;
        `ADDR_CNT1:  s_d.cnt1 = wdata_in;
        `ADDR_SAVE:  s_d.save = wdata_in;
        default:     s_d.cnt0 = s_d.cnt0;
      endcase
    end

    if (rd_in) begin
      unique case (addr_in)
        `ADDR_CTRL:   s_d.rdata = s_q.cr;
        `ADDR_EVSEL:  s_d.rdata = {10'h000, s_q.sel1, 10'h000, s_q.sel0};
        `ADDR_CNT0:   s_d.rdata = s_q.cnt0;
        `ADDR_CNT1:   s_d.rdata = s_q.cnt1;
        `ADDR_SAVE:   s_d.rdata = s_q.save;
        `ADDR_STATUS: s_d.rdata = {30'h0000_0000, s_q.st[2], s_q.st[1]};
        default:      s_d.rdata = 32'h0000_0000;
      endcase
    end

    if (counter_read_instr_in) begin
      if (s_q.cr[`CR_PCE_BIT] || (cpl_in == 2'h0)) begin // [RL3]
        s_d.rvalid = 1'b1;
        s_d.rddata = counter_sel_in ? s_q.cnt1 : s_q.cnt0;
      end else begin
        s_d.rfault = 1'b1; // [RL3]
      end
    end

    unique case (s_q.st)
      perf_pkg::ST_RUN: begin
        if (sysmgmt_enter_in) begin
          s_d.save = s_q.cr; // [RL4]
          s_d.st   = perf_pkg::ST_MGMT;
        end
      end
      perf_pkg::ST_MGMT: begin
        if (resume_from_sysmgmt_in) begin
          if ((s_q.save & ~`CR_DEF_MASK) == 32'h0000_0000) begin // [RL5]
            s_d.cr = s_q.save; // [RL4]
            s_d.st = perf_pkg::ST_RUN;
          end else begin
            s_d.st = perf_pkg::ST_HALT;
          end
        end
      end
      perf_pkg::ST_HALT: s_d.st = perf_pkg::ST_HALT;
      default:           s_d.st = perf_pkg::ST_HALT;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= MAIN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // monitor pins
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      pin_rate_encoder u_enc (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .io_tick_in (s_q.tick),
        .inc_in     ((gi == 0) ? inc0 : inc1), // [RL1] [RL11]
        .pin_out    (monitor_status_pins_out[gi])
      );
    end
  endgenerate

  assign rdata_out                  = s_q.rdata;
  assign read_valid_out             = s_q.rvalid;
  assign read_fault_out             = s_q.rfault;
  assign read_data_out              = s_q.rddata;
  assign system_management_mode_out = s_q.st[1];
  assign shutdown_out               = s_q.st[2];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence mgmt_entry_s;
    sysmgmt_enter_in && (s_q.st == perf_pkg::ST_RUN);
  endsequence

  sequence resume_clean_s;
    resume_from_sysmgmt_in && (s_q.st == perf_pkg::ST_MGMT)
      && ((s_q.save & ~`CR_DEF_MASK) == 32'h0000_0000);
  endsequence

  sequence resume_dirty_s;
    resume_from_sysmgmt_in && (s_q.st == perf_pkg::ST_MGMT)
      && ((s_q.save & ~`CR_DEF_MASK) != 32'h0000_0000);
  endsequence

  read_allowed_a: assert property ( // [RL3]
    (counter_read_instr_in && s_q.cr[`CR_PCE_BIT])
      |=> (read_valid_out && !read_fault_out
           && (read_data_out == ($past(counter_sel_in) ? $past(s_q.cnt1) : $past(s_q.cnt0)))))
    else $error("enabled counter read refused");

  read_level0_a: assert property ( // [RL3]
    (counter_read_instr_in && (cpl_in == 2'h0)) |=> (read_valid_out && !read_fault_out))
    else $error("level 0 counter read refused");

  read_blocked_a: assert property ( // [RL3]
    (counter_read_instr_in && !s_q.cr[`CR_PCE_BIT] && (cpl_in != 2'h0))
      |=> (read_fault_out && !read_valid_out))
    else $error("user counter read not faulted");

  mgmt_save_a: assert property ( // [RL4]
    mgmt_entry_s |=> ((s_q.save == $past(s_q.cr)) && system_management_mode_out))
    else $error("control register not saved on entry");

  resume_restore_a: assert property ( // [RL5]
    resume_clean_s |=> ((s_q.cr == $past(s_q.save)) && !shutdown_out
                        && !system_management_mode_out))
    else $error("clean resume did not restore");

  resume_reserved_a: assert property ( // [RL5]
    resume_dirty_s |=> shutdown_out ##1 shutdown_out)
    else $error("reserved bits did not shut down");

  nc_write_count_a: assert property ( // [RL6]
    ((s_q.sel0 == perf_pkg::EV_NC_WRITE) && !cnt0_wr)
      |=> (s_q.cnt0 == $past(s_q.cnt0) + 32'($past(nc_write_in))
                                       + 32'($past(simd_nc_write_in))))
    else $error("non-cacheable write miscounted");

  wr_stall_count_a: assert property ( // [RL7]
    ((s_q.sel1 == perf_pkg::EV_WR_STALL) && !s_q.cr[`CR_VAR_BIT] && !cnt1_wr
      && simd_wr_stall_in && wb_nonempty_in)
      |=> (s_q.cnt1 == $past(s_q.cnt1) + 32'h0000_0001))
    else $error("write stall with busy buffers not counted");

  wbuf_stall_count_a: assert property ( // [RL7]
    ((s_q.sel1 == perf_pkg::EV_WR_STALL) && !s_q.cr[`CR_VAR_BIT] && !cnt1_wr
      && simd_wr_stall_in && !wb_nonempty_in && s_q.wbuf_n[1])
      |=> (s_q.cnt1 == $past(s_q.cnt1) + 32'h0000_0001))
    else $error("write stall with write-empty off not counted");

  miss_once_a: assert property ( // [RL8]
    ((s_q.sel0 == perf_pkg::EV_RD_MISS) && !cnt0_wr && simd_rd_miss_in)
      |=> (s_q.cnt0 == $past(s_q.cnt0) + 32'h0000_0001))
    else $error("read miss counted other than once");

  wr_miss_once_a: assert property ( // [RL8]
    ((s_q.sel1 == perf_pkg::EV_WR_MISS) && !cnt1_wr && simd_wr_miss_in)
      |=> (s_q.cnt1 == $past(s_q.cnt1) + 32'h0000_0001))
    else $error("write miss counted other than once");

  misalign_three_a: assert property ( // [RL9]
    ((s_q.sel0 == perf_pkg::EV_RD_STALL) && !cnt0_wr
      && rd_misalign_done_in && !tlb_miss_in)
      |=> (s_q.cnt0 == $past(s_q.cnt0) + 32'h0000_0003))
    else $error("misaligned read not charged three clocks");

  tlb_miss_stall_a: assert property ( // [RL9]
    ((s_q.sel0 == perf_pkg::EV_RD_STALL) && !cnt0_wr
      && rd_misalign_done_in && tlb_miss_in)
      |=> (s_q.cnt0 == $past(s_q.cnt0) + 32'($past(rd_stall_clk_in))))
    else $error("misaligned read with translation miss overcharged");

  mul_count_a: assert property ( // [RL10]
    ((s_q.sel1 == perf_pkg::EV_WR_STALL) && s_q.cr[`CR_VAR_BIT] && !cnt1_wr
      && mul_interlock_in && !branch_taken_in)
      |=> (s_q.cnt1 == $past(s_q.cnt1) + 32'h0000_0001))
    else $error("multiply interlock clock not counted");

  branch_no_count_a: assert property ( // [RL10]
    ((s_q.sel0 == perf_pkg::EV_WR_STALL) && s_q.cr[`CR_VAR_BIT] && !cnt0_wr
      && branch_taken_in)
      |=> $stable(s_q.cnt0))
    else $error("interlock counted across taken branch");

endmodule : perf_event_counter_unit
`default_nettype wire

// file: perf_event_counter_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "perf_cfg.svh"
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module perf_event_counter_unit_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr   = 8'h00;
  logic [31:0] wdata  = 32'h0000_0000;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic [9:0]  ev     = 10'h000;
  logic        wb     = 1'b0;
  logic        wbuf_n = 1'b1;
  logic        cri_q  = 1'b0;
  logic [1:0]  cpl    = 2'h0;
  logic        csel   = 1'b0;
  logic        smi    = 1'b0;
  logic        exit_q = 1'b0;
  logic [31:0] rdata, rdat2, rv;
  logic        rvalid, rfault, mgmt, shut, rate_err;
  logic [1:0]  pins;
  logic [15:0] tog0, tog1;
  logic [15:0] tot0 = 16'h0000;
  logic [15:0] tot1 = 16'h0000;
  int          errors = 0;
  int          comparisons = 0;

  always #5 clk_in = ~clk_in;

  perf_event_counter_unit dut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .nc_write_in(ev[0]), .simd_nc_write_in(ev[1]),
    .simd_wr_stall_in(ev[2]), .wb_nonempty_in(wb), .ext_write_buffer_empty_n_in(wbuf_n),
    .simd_rd_miss_in(ev[3]), .simd_wr_miss_in(ev[4]), .rd_stall_clk_in(ev[5]),
    .rd_misalign_done_in(ev[6]), .tlb_miss_in(ev[7]), .mul_interlock_in(ev[8]),
    .branch_taken_in(ev[9]), .counter_read_instr_in(cri_q), .cpl_in(cpl),
    .counter_sel_in(csel), .read_valid_out(rvalid), .read_fault_out(rfault),
    .read_data_out(rdat2), .sysmgmt_enter_in(smi), .resume_from_sysmgmt_in(exit_q),
    .system_management_mode_out(mgmt), .shutdown_out(shut), .monitor_status_pins_out(pins));

  pin_monitor_model mon (.clk_in(clk_in), .rst_in(rst_in), .pins_in(pins),
    .toggles0_out(tog0), .toggles1_out(tog1), .rate_err_out(rate_err));

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    rv = rdata;
    `CHECK(nm, ex, rv)
  endtask : rd_chk

  task automatic run_ev(input logic [5:0] code, input logic var1, input logic c1,
                        input logic [9:0] mask, input int n, input logic [31:0] ex);
    wr_reg(`ADDR_CTRL, {30'h0, var1, 1'b0});
    wr_reg(`ADDR_EVSEL, c1 ? {10'h0, code, 16'h0} : {26'h0, code});
    wr_reg(c1 ? `ADDR_CNT1 : `ADDR_CNT0, 32'h0000_0000);
    repeat (n) @(posedge clk_in) ev <= mask;
    @(posedge clk_in) ev <= 10'h000;
    repeat (2) @(posedge clk_in);
    rd_chk(c1 ? `ADDR_CNT1 : `ADDR_CNT0, ex, "event count");
    if (c1) tot1 += ex[15:0];
    else tot0 += ex[15:0];
  endtask : run_ev

  task automatic cri(input logic [1:0] lvl, input logic s, input logic ok,
                     input logic [31:0] ex);
    @(posedge clk_in);
    cri_q <= 1'b1;
    cpl <= lvl;
    csel <= s;
    @(posedge clk_in);
    cri_q <= 1'b0;
    #1;
    `CHECK("read valid", ok, rvalid)
    `CHECK("read fault", !ok, rfault)
    `CHECK("read data", ok ? ex : 32'h0000_0000, rdat2)
  endtask : cri

  task automatic pulse(input logic resume);
    @(posedge clk_in);
    if (resume) exit_q <= 1'b1;
    else smi <= 1'b1;
    @(posedge clk_in);
    smi <= 1'b0;
    exit_q <= 1'b0;
    #1;
  endtask : pulse

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(`ADDR_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(`ADDR_STATUS, 32'h0000_0000, "status reset");
    rd_chk(8'h40, 32'h0000_0000, "unmapped");
    run_ev(perf_pkg::EV_NC_WRITE, 1'b0, 1'b0, 10'h001, 2, 32'h0000_0002);
    run_ev(perf_pkg::EV_NC_WRITE, 1'b0, 1'b0, 10'h003, 3, 32'h0000_0006);
    @(posedge clk_in) wb <= 1'b1;
    wbuf_n <= 1'b0;
    run_ev(perf_pkg::EV_WR_STALL, 1'b0, 1'b1, 10'h004, 4, 32'h0000_0004);
    @(posedge clk_in) wb <= 1'b0;
    wbuf_n <= 1'b1;
    run_ev(perf_pkg::EV_WR_STALL, 1'b0, 1'b1, 10'h004, 4, 32'h0000_0004);
    @(posedge clk_in) wbuf_n <= 1'b0;
    run_ev(perf_pkg::EV_WR_STALL, 1'b0, 1'b1, 10'h004, 4, 32'h0000_0000);
    run_ev(perf_pkg::EV_RD_MISS, 1'b0, 1'b0, 10'h008, 5, 32'h0000_0005);
    run_ev(perf_pkg::EV_WR_MISS, 1'b0, 1'b1, 10'h010, 5, 32'h0000_0005);
    run_ev(perf_pkg::EV_RD_STALL, 1'b0, 1'b0, 10'h020, 2, 32'h0000_0002);
    run_ev(perf_pkg::EV_RD_STALL, 1'b0, 1'b0, 10'h060, 1, 32'h0000_0003);
    run_ev(perf_pkg::EV_RD_STALL, 1'b0, 1'b0, 10'h0e0, 2, 32'h0000_0002);
    run_ev(perf_pkg::EV_WR_STALL, 1'b1, 1'b1, 10'h100, 4, 32'h0000_0004);
    run_ev(perf_pkg::EV_WR_STALL, 1'b1, 1'b0, 10'h300, 3, 32'h0000_0000);
    repeat (200) @(posedge clk_in);
    `CHECK("pin0 toggles", tot0, tog0)
    `CHECK("pin1 toggles", tot1, tog1)
    `CHECK("pin rate", 1'b0, rate_err)
    wr_reg(`ADDR_CTRL, 32'h0000_0000);
    wr_reg(`ADDR_CNT0, 32'h1234_5678);
    wr_reg(`ADDR_CNT1, 32'h0000_00a5);
    for (int l = 0; l < 4; l++) cri(2'(l), 1'b0, l == 0, 32'h1234_5678);
    wr_reg(`ADDR_CTRL, 32'h0000_0001);
    for (int l = 0; l < 4; l++) cri(2'(l), 1'b1, 1'b1, 32'h0000_00a5);
    wr_reg(`ADDR_CTRL, 32'h0000_0003);
    pulse(1'b0);
    `CHECK("mgmt entered", 1'b1, mgmt)
    rd_chk(`ADDR_SAVE, 32'h0000_0003, "saved ctrl");
    rd_chk(`ADDR_STATUS, 32'h0000_0001, "status mgmt");
    wr_reg(`ADDR_CTRL, 32'h0000_0000);
    pulse(1'b1);
    `CHECK("mgmt left", 1'b0, mgmt)
    `CHECK("no shutdown", 1'b0, shut)
    rd_chk(`ADDR_CTRL, 32'h0000_0003, "restored ctrl");
    pulse(1'b0);
    wr_reg(`ADDR_SAVE, 32'h0000_0103);
    pulse(1'b1);
    `CHECK("reserved shutdown", 1'b1, shut)
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end
endmodule : perf_event_counter_unit_tb
`default_nettype wire

// file: perf_pkg.sv
`default_nettype none
package perf_pkg;

  typedef enum logic [5:0] {
    EV_NC_WRITE  = 6'h2e,
    EV_RD_MISS   = 6'h31,
    EV_WR_MISS   = 6'h34,
    EV_RD_STALL  = 6'h36,
    EV_WR_STALL  = 6'h3b
  } event_code_t;

  typedef enum logic [2:0] {
    ST_RUN  = 3'h1,
    ST_MGMT = 3'h2,
    ST_HALT = 3'h4
  } sys_state_t;

  typedef struct packed {
    sys_state_t  st;
    logic [31:0] cr;
    logic [31:0] save;
    logic [31:0] cnt0;
    logic [31:0] cnt1;
    logic [5:0]  sel0;
    logic [5:0]  sel1;
    logic [3:0]  div;
    logic        tick;
    logic [31:0] rdata;
    logic        rvalid;
    logic        rfault;
    logic [31:0] rddata;
    logic [1:0]  wbuf_n;
  } main_state_t;

  typedef struct packed {
    logic        pin;
    logic [15:0] pend;
  } enc_state_t;

endpackage : perf_pkg
`default_nettype wire

// file: pin_monitor_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// external monitor: counts pin toggles, flags toggles faster than io rate
// ----------------------------------------------------------------------
module pin_monitor_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [1:0]  pins_in,
  output var  logic [15:0] toggles0_out,
  output var  logic [15:0] toggles1_out,
  output var  logic        rate_err_out
);
  logic [1:0]  prev_q;
  logic [3:0]  gap_q [2];
  logic [15:0] cnt_q [2];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q       <= 2'h0;
      rate_err_out <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        gap_q[i] <= 4'hf;
        cnt_q[i] <= 16'h0000;
      end
    end else begin
      prev_q <= pins_in;
      for (int i = 0; i < 2; i++) begin
        if (pins_in[i] != prev_q[i]) begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
          gap_q[i] <= 4'h0;
          if (gap_q[i] < 4'h2) rate_err_out <= 1'b1;
        end else if (gap_q[i] != 4'hf) begin
          gap_q[i] <= gap_q[i] + 4'h1;
        end
      end
    end
  end

  assign toggles0_out = cnt_q[0];
  assign toggles1_out = cnt_q[1];
endmodule : pin_monitor_model
`default_nettype wire

// file: pin_rate_encoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "perf_cfg.svh"

module pin_rate_encoder (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       io_tick_in,
  input  wire logic [1:0] inc_in,
  output var  logic       pin_out
);

  perf_pkg::enc_state_t s_q;
  perf_pkg::enc_state_t s_d;
  logic [`PEND_W:0]     sum;

  // ----------------------------------------------------------------------
  // one toggle per increment until the 16-bit pending count saturates, at most one toggle per io tick
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    sum = {1'b0, s_q.pend} + {{(`PEND_W - 1){1'b0}}, inc_in};
    if (io_tick_in && (s_q.pend != '0)) begin // [RL2] [RL11]
      s_d.pin = ~s_q.pin; // [RL1]
      sum     = sum - {{`PEND_W{1'b0}}, 1'b1};
    end
    s_d.pend = sum[`PEND_W] ? {`PEND_W{1'b1}} : sum[`PEND_W-1:0]; // [RL11]
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.pin;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  pin_on_tick_a: assert property ( // [RL2]
    (s_q.pin != $past(s_q.pin)) |-> ($past(io_tick_in) && ($past(s_q.pend) != '0)))
    else $error("pin moved outside an io tick");

  drain_pending_a: assert property ( // [RL1]
    (io_tick_in && (s_q.pend != '0)) |=> (s_q.pin != $past(s_q.pin)))
    else $error("pending increment not shown on pin");

  pend_conserve_a: assert property ( // [RL11]
    (s_q.pend < 16'hfff0) |=>
      (s_q.pend == $past(s_q.pend) + 16'($past(inc_in))
                   - 16'($past(io_tick_in) && ($past(s_q.pend) != '0))))
    else $error("increment lost or duplicated");

endmodule : pin_rate_encoder
`default_nettype wire
